//--- common/pso_pkg.sv
// Purpose: Shared constants and types for the phase-shed and
//          over-temperature settings block.
// Assumes: 8-bit command codes, 16-bit register words.
// Notes:   Reset values are plain defaults, overridable per instance.
package pso_pkg;
	// Command codes
	localparam logic [7:0] PSO_ADDR_LVL32 = 8'hE4;
	localparam logic [7:0] PSO_ADDR_LVL54 = 8'hE5;
	localparam logic [7:0] PSO_ADDR_SPA = 8'hE6;
	localparam logic [7:0] PSO_ADDR_SPB = 8'hE7;
	localparam logic [7:0] PSO_ADDR_HYS = 8'hE8;
	localparam logic [7:0] PSO_ADDR_OT = 8'hE9;
	// Field positions
	localparam int PSO_HI_MSB = 15;
	localparam int PSO_HI_LSB = 8;
	localparam int PSO_LO_MSB = 7;
	localparam int PSO_OT_EN_BIT = 15;
	localparam int PSO_OT_RESP_BIT = 14;
	localparam int PSO_OT_HYS_MSB = 13;
	localparam int PSO_OT_HYS_LSB = 8;
	// Fixed and reset values
	localparam logic [15:0] PSO_SPARE_VAL = 16'hFFFF;
	localparam logic [15:0] PSO_RST_LVL32 = 16'h0000;
	localparam logic [15:0] PSO_RST_LVL54 = 16'h0000;
	localparam logic [7:0] PSO_RST_HYS = 8'h00;
	localparam logic [15:0] PSO_RST_OT = 16'h0000;
	// Threshold and phase counts, current input width
	localparam int PSO_NUM_TH = 6;
	localparam logic [2:0] PSO_MAX_PH = 3'h6;
	localparam logic [2:0] PSO_MIN_PH = 3'h1;
	localparam int PSO_IW = 10;
	// Shedding levels, full phase count first
	typedef enum logic [2:0] {
		PSO_P6, PSO_P5, PSO_P4, PSO_P3, PSO_P2,
		PSO_P1C, PSO_P1D
	} pso_phase_t;
	typedef enum logic [1:0] {
		PSO_OT_IDLE, PSO_OT_HICCUP, PSO_OT_LATCH
	} pso_ot_t;
endpackage

//--- hdl/pso_settings.sv
// Purpose: Phase-shed thresholds, shed hysteresis and sense-input
//          over-temperature settings, with their comparison logic.
// Assumes: Current and sense codes come from same-clock logic.
// Notes:   Register port is the device's own command-code access.
// Overview of operation
// - With auto shedding on, total current sets how many phases stay on.
// - Drop-to-three threshold sits in the upper byte of word E4.
// - Drop-to-two threshold sits in the lower byte of word E4.
// - Drop-to-five threshold sits in the upper byte of word E5.
// - Drop-to-four threshold sits in the lower byte of word E5.
// - Thresholds and hysteresis count 1 A, or 2 A when scale select is 1.
// - An eight-bit field holds the shedding current hysteresis.
// - Sense over-temperature protection works only while bit 15 is one.
// - Bit 14 picks response: zero hiccup recovery, one latch off.
// - Six-bit code sets hysteresis for leaving hiccup protection.
// - Protection trips when sensed code crosses the eight-bit threshold.
// - Single-phase CCM and DCM thresholds use the same current scaling.
`timescale 1ns/1ps
`default_nettype none
module pso_settings #(
	parameter int IW = pso_pkg::PSO_IW,
	parameter logic [15:0] RST_LVL32 = pso_pkg::PSO_RST_LVL32,
	parameter logic [15:0] RST_LVL54 = pso_pkg::PSO_RST_LVL54,
	parameter logic [7:0] RST_HYS = pso_pkg::PSO_RST_HYS,
	parameter logic [15:0] RST_OT = pso_pkg::PSO_RST_OT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_code,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_ack,
	output logic reg_miss,
	// Shedding inputs
	input wire logic auto_phase_shedding,
	input wire logic total_amp_scale_select,
	input wire logic [15:0] single_levels,
	input wire logic [IW-1:0] total_amps,
	// Shedding outputs
	output logic [2:0] active_phases,
	output logic single_discontinuous,
	// Temperature sense
	input wire logic [7:0] temp_sense_input,
	output logic overtemp_active,
	output logic overtemp_latched
);
	import pso_pkg::*;

	localparam int SW = IW + 2;

	logic rst_q1, rst_q2;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end
	wire logic rstn = rst_q2;

	// Register file
	logic [15:0] lvl32_reg, lvl32_next;
	logic [15:0] lvl54_reg, lvl54_next;
	logic [7:0] hys_reg, hys_next;
	logic [15:0] ot_reg, ot_next;
	logic [15:0] rdata_next;
	logic hit;

	always_comb begin
		lvl32_next = lvl32_reg;
		lvl54_next = lvl54_reg;
		hys_next = hys_reg;
		ot_next = ot_reg;
		rdata_next = 16'h0000;
		hit = 1'b1;
		case (reg_code)
			PSO_ADDR_LVL32: begin
				if (reg_wr)
					lvl32_next = reg_wdata;
				rdata_next = lvl32_reg;
			end
			PSO_ADDR_LVL54: begin
				if (reg_wr)
					lvl54_next = reg_wdata;
				rdata_next = lvl54_reg;
			end
			// Spare levels are fixed; writes are dropped
			PSO_ADDR_SPA, PSO_ADDR_SPB: rdata_next = PSO_SPARE_VAL;
			PSO_ADDR_HYS: begin
				if (reg_wr)
					hys_next = reg_wdata[PSO_LO_MSB:0];
				rdata_next = {8'h00, hys_reg};
			end
			PSO_ADDR_OT: begin
				if (reg_wr)
					ot_next = reg_wdata;
				rdata_next = ot_reg;
			end
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl32_reg <= RST_LVL32;
			lvl54_reg <= RST_LVL54;
			hys_reg <= RST_HYS;
			ot_reg <= RST_OT;
			reg_rdata <= 16'h0000;
			reg_ack <= 1'b0;
			reg_miss <= 1'b0;
		end else begin
			lvl32_reg <= lvl32_next;
			lvl54_reg <= lvl54_next;
			hys_reg <= hys_next;
			ot_reg <= ot_next;
			reg_rdata <= reg_rd ? rdata_next : 16'h0000;
			reg_ack <= reg_rd | reg_wr;
			reg_miss <= (reg_rd | reg_wr) & ~hit;
		end
	end

	// Thresholds, index k is the drop from level k to k+1
	logic [7:0] th_raw [PSO_NUM_TH];
	logic [SW-1:0] th_amp [PSO_NUM_TH];
	logic [SW-1:0] hys_amp;
	assign th_raw[0] = lvl54_reg[PSO_HI_MSB:PSO_HI_LSB];
	assign th_raw[1] = lvl54_reg[PSO_LO_MSB:0];
	assign th_raw[2] = lvl32_reg[PSO_HI_MSB:PSO_HI_LSB];
	assign th_raw[3] = lvl32_reg[PSO_LO_MSB:0];
	assign th_raw[4] = single_levels[PSO_HI_MSB:PSO_HI_LSB];
	assign th_raw[5] = single_levels[PSO_LO_MSB:0];

	// Scaling keeps the coarse step by shifting, so no multiplier
	genvar gi;
	generate
		for (gi = 0; gi < PSO_NUM_TH; gi++) begin : g_scale
			assign th_amp[gi] = total_amp_scale_select ?
				SW'({th_raw[gi], 1'b0}) : SW'(th_raw[gi]);
		end
	endgenerate
	assign hys_amp = total_amp_scale_select ?
		SW'({hys_reg, 1'b0}) : SW'(hys_reg);

	// Shedding level machine
	pso_phase_t ph_reg, ph_next;
	logic [2:0] ph_idx;
	logic [SW-1:0] amps, drop_th, rise_th;
	logic [2:0] phases_next;

	assign ph_idx = 3'(ph_reg);
	assign amps = SW'(total_amps);

	always_comb begin
		drop_th = '0;
		rise_th = '0;
		if (ph_idx < 3'(PSO_NUM_TH))
			drop_th = th_amp[ph_idx];
		if (ph_idx != 3'h0)
			rise_th = th_amp[ph_idx - 3'h1] + hys_amp;
	end

	always_comb begin
		ph_next = ph_reg;
		if (!auto_phase_shedding) begin
			ph_next = PSO_P6;
		end else begin
			// One level per cycle keeps each step observable
			case (ph_reg)
				PSO_P6: begin
					if (amps < drop_th)
						ph_next = PSO_P5;
				end
				PSO_P5, PSO_P4, PSO_P3, PSO_P2, PSO_P1C: begin
					if (amps > rise_th)
						ph_next = pso_phase_t'(ph_idx - 3'h1);
					else if (amps < drop_th)
						ph_next = pso_phase_t'(ph_idx + 3'h1);
				end
				PSO_P1D: begin
					if (amps > rise_th)
						ph_next = PSO_P1C;
				end
				default: ph_next = PSO_P6;
			endcase
		end
		if (ph_next == PSO_P1C || ph_next == PSO_P1D)
			phases_next = PSO_MIN_PH;
		else
			phases_next = PSO_MAX_PH - 3'(ph_next);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_reg <= PSO_P6;
			active_phases <= PSO_MAX_PH;
			single_discontinuous <= 1'b0;
		end else begin
			ph_reg <= ph_next;
			active_phases <= phases_next;
			single_discontinuous <= (ph_next == PSO_P1D);
		end
	end

	// Sense over-temperature
	pso_ot_t ot_st_reg, ot_st_next;
	logic ot_en, ot_resp;
	logic [7:0] ot_thre, ot_hys, ot_exit;
	assign ot_en = ot_reg[PSO_OT_EN_BIT];
	assign ot_resp = ot_reg[PSO_OT_RESP_BIT];
	assign ot_thre = ot_reg[PSO_LO_MSB:0];
	assign ot_hys = 8'(ot_reg[PSO_OT_HYS_MSB:PSO_OT_HYS_LSB]);
	// Floor at zero so a large hysteresis cannot wrap
	assign ot_exit = (ot_hys > ot_thre) ? 8'h00 : ot_thre - ot_hys;

	always_comb begin
		ot_st_next = ot_st_reg;
		if (!ot_en) begin
			ot_st_next = PSO_OT_IDLE;
		end else begin
			case (ot_st_reg)
				PSO_OT_IDLE: begin
					if (temp_sense_input >= ot_thre)
						ot_st_next = ot_resp ? PSO_OT_LATCH
							: PSO_OT_HICCUP;
				end
				PSO_OT_HICCUP: begin
					if (temp_sense_input < ot_exit)
						ot_st_next = PSO_OT_IDLE;
				end
				// Latched off until protection is disabled or reset
				PSO_OT_LATCH: ot_st_next = PSO_OT_LATCH;
				default: ot_st_next = PSO_OT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ot_st_reg <= PSO_OT_IDLE;
			overtemp_active <= 1'b0;
			overtemp_latched <= 1'b0;
		end else begin
			ot_st_reg <= ot_st_next;
			overtemp_active <= (ot_st_next != PSO_OT_IDLE);
			overtemp_latched <= (ot_st_next == PSO_OT_LATCH);
		end
	end

	// Checks
	shed_off_full_a: assert property (@(posedge clk) disable iff (!rstn)
		!auto_phase_shedding |=> active_phases == PSO_MAX_PH)
		else $error("phase count not full with shedding off");
	shed_drop_a: assert property (@(posedge clk) disable iff (!rstn)
		auto_phase_shedding && ph_reg == PSO_P6 && amps < th_amp[0]
		|=> active_phases == PSO_MAX_PH - 3'h1)
		else $error("no drop to five below threshold");
	lvl32_bytes_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && reg_code == PSO_ADDR_LVL32 |=> th_raw[2] ==
		$past(reg_wdata[PSO_HI_MSB:PSO_HI_LSB]) &&
		th_raw[3] == $past(reg_wdata[PSO_LO_MSB:0]))
		else $error("E4 byte lanes misplaced");
	lvl54_bytes_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && reg_code == PSO_ADDR_LVL54 ##1 reg_rd &&
		reg_code == PSO_ADDR_LVL54 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("E5 readback mismatch");
	hys_read_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_rd && reg_code == PSO_ADDR_HYS |=>
		reg_rdata[PSO_HI_MSB:PSO_HI_LSB] == 8'h00)
		else $error("hysteresis upper byte not zero");
	shed_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		auto_phase_shedding && ph_reg == PSO_P5 && amps >= th_amp[0] &&
		amps <= rise_th |=> ph_reg == PSO_P5)
		else $error("level changed inside hysteresis band");
	ot_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!ot_en |=> !overtemp_active && !overtemp_latched)
		else $error("protection active while disabled");
	ot_trip_a: assert property (@(posedge clk) disable iff (!rstn)
		ot_en && ot_st_reg == PSO_OT_IDLE && temp_sense_input >= ot_thre
		|=> overtemp_active && overtemp_latched == $past(ot_resp))
		else $error("trip missed or wrong response");
	ot_latch_a: assert property (@(posedge clk) disable iff (!rstn)
		overtemp_latched && ot_en ##1 ot_en |-> overtemp_latched)
		else $error("latched protection released");
	ot_exit_a: assert property (@(posedge clk) disable iff (!rstn)
		ot_en && ot_st_reg == PSO_OT_HICCUP && temp_sense_input < ot_exit
		|=> !overtemp_active)
		else $error("hiccup exit missed");
endmodule
`default_nettype wire

//--- test/pso_settings_bench.sv
// Purpose: Self-checking bench for the phase-shed and sense settings.
// Assumes: Inputs driven at the falling edge, checked at the next falling edge.
// Notes:   Thresholds picked so every drop and rise lands on a known edge.
`timescale 1ns/1ps
`default_nettype none
module pso_settings_bench;
	import pso_pkg::*;
	logic clk, resetn, reg_wr, reg_rd, auto_on, scale_sel;
	logic [7:0] reg_code, sense;
	logic [15:0] reg_wdata, reg_rdata, single_levels;
	logic [PSO_IW-1:0] amps;
	logic reg_ack, reg_miss, single_dcm, ot_active, ot_latched;
	logic [2:0] phases;
	logic [2:0] down_seq [6] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1};
	logic [2:0] up_seq [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	int failures, n_compared;

	pso_settings i_pso_settings (.clk(clk), .resetn(resetn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_code(reg_code),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_miss(reg_miss), .auto_phase_shedding(auto_on),
		.total_amp_scale_select(scale_sel), .single_levels(single_levels),
		.total_amps(amps), .active_phases(phases),
		.single_discontinuous(single_dcm), .temp_sense_input(sense),
		.overtemp_active(ot_active), .overtemp_latched(ot_latched));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Strobes stay up after a call so back-to-back accesses need no gap;
	// idle drops them and checks that the ack clears one cycle later
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		reg_wr = 1'b1;
		reg_rd = 1'b0;
		reg_code = code;
		reg_wdata = data;
		step(1);
		chk("write ack", 16'h0001, {15'h0000, reg_ack});
	endtask

	task automatic idle;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		step(1);
		chk("ack drop", 16'h0000, {15'h0000, reg_ack});
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] exp,
		input logic miss);
		reg_rd = 1'b1;
		reg_wr = 1'b0;
		reg_code = code;
		step(1);
		chk("read ack", 16'h0001, {15'h0000, reg_ack});
		chk("read miss", {15'h0000, miss}, {15'h0000, reg_miss});
		chk("read data", exp, reg_rdata);
	endtask

	task automatic ph(input logic [2:0] exp);
		step(1);
		chk("phases", {13'h0000, exp}, {13'h0000, phases});
	endtask

	task automatic ot(input logic [7:0] s, input logic a, input logic l);
		sense = s;
		step(1);
		chk("ot active", {15'h0000, a}, {15'h0000, ot_active});
		chk("ot latched", {15'h0000, l}, {15'h0000, ot_latched});
	endtask

	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Whole run is under a hundred cycles; this is far beyond it
	initial begin
		#20000;
		failures++;
		end_sim();
	end

	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_code = 8'h00;
		reg_wdata = 16'h0000;
		auto_on = 1'b0;
		scale_sel = 1'b0;
		single_levels = 16'h1008;
		amps = 10'h000;
		sense = 8'h00;
		step(20);
		resetn = 1'b1;
		step(3);
		rd(PSO_ADDR_LVL32, 16'h0000, 1'b0);
		rd(PSO_ADDR_LVL54, 16'h0000, 1'b0);
		rd(PSO_ADDR_HYS, 16'h0000, 1'b0);
		rd(PSO_ADDR_OT, 16'h0000, 1'b0);
		wr(PSO_ADDR_LVL32, 16'h3020);
		rd(PSO_ADDR_LVL32, 16'h3020, 1'b0);
		wr(PSO_ADDR_LVL54, 16'h5040);
		rd(PSO_ADDR_LVL54, 16'h5040, 1'b0);
		wr(PSO_ADDR_HYS, 16'hAB04);
		rd(PSO_ADDR_HYS, 16'h0004, 1'b0);
		wr(PSO_ADDR_SPB, 16'h1234);
		rd(PSO_ADDR_SPB, 16'hFFFF, 1'b0);
		rd(PSO_ADDR_SPA, 16'hFFFF, 1'b0);
		wr(8'h10, 16'h5555);
		rd(8'h10, 16'h0000, 1'b1);
		idle();
		// One level per edge down to single-phase discontinuous
		auto_on = 1'b1;
		foreach (down_seq[i]) ph(down_seq[i]);
		chk("single dcm", 16'h0001, {15'h0000, single_dcm});
		amps = 10'h3FF;
		foreach (up_seq[i]) ph(up_seq[i]);
		amps = 10'd79;
		ph(3'h5);
		amps = 10'd84;
		ph(3'h5);
		amps = 10'd85;
		ph(3'h6);
		// Doubled scale: 150 A is below 160 A, rise needs over 168 A
		scale_sel = 1'b1;
		amps = 10'd150;
		ph(3'h5);
		amps = 10'd168;
		ph(3'h5);
		amps = 10'd169;
		ph(3'h6);
		amps = 10'd0;
		ph(3'h5);
		auto_on = 1'b0;
		ph(3'h6);
		ph(3'h6);
		ot(8'h40, 1'b0, 1'b0);
		ot(8'h00, 1'b0, 1'b0);
		wr(PSO_ADDR_OT, 16'h8540);
		idle();
		ot(8'h3F, 1'b0, 1'b0);
		ot(8'h40, 1'b1, 1'b0);
		ot(8'h3B, 1'b1, 1'b0);
		ot(8'h3A, 1'b0, 1'b0);
		wr(PSO_ADDR_OT, 16'hC540);
		idle();
		ot(8'h40, 1'b1, 1'b1);
		ot(8'h00, 1'b1, 1'b1);
		wr(PSO_ADDR_OT, 16'h4540);
		idle();
		ot(8'h00, 1'b0, 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
